// File: sim/ecsl_link_tb.sv
////////////////////////////////////////////////////////////////////////////////
module ecsl_link_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic tx_word_clock = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] word_in = 10'h000;
    logic [9:0] far_word = 10'h000;
    logic edge_sel = 1'b1;
    logic sync_a = 1'b0;
    logic sync_b = 1'b0;
    logic drive_en = 1'b1;
    logic pwr_n = 1'b1;
    logic rx_oe = 1'b1;
    logic rx_edge = 1'b1;
    logic far_break = 1'b0;
    logic serial_in, serial_out, serial_oe, tx_ready, word_oe, rx_clk, rx_clk_oe, lock_n;
    logic [9:0] word_out;
    logic [11:0] win = 12'h000;
    int errors = 0;
    int compares = 0;
    // each row: transmit and receive edge select, then the word sent both ways
    logic [10:0] rows [0:3] = '{11'h400, 11'h3ff, 11'h555, 11'h2aa};

    always #50 sys_clk = ~sys_clk;
    always #1000 tx_word_clock = ~tx_word_clock;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end

    ecsl_link ecsl_link_i (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_link_clk(link_clk),
        .i_tx_word_clock(tx_word_clock), .i_parallel_word_in(word_in),
        .i_tx_edge_select(edge_sel), .i_sync_request_a(sync_a),
        .i_sync_request_b(sync_b), .i_tx_drive_enable(drive_en),
        .i_power_down_n(pwr_n), .i_rx_edge_select(rx_edge),
        .i_rx_output_enable(rx_oe), .i_serial_in(serial_in),
        .o_serial_out(serial_out), .o_serial_oe(serial_oe), .o_tx_ready(tx_ready),
        .o_parallel_word_out(word_out), .o_parallel_word_oe(word_oe),
        .o_rx_clk_out(rx_clk), .o_rx_clk_oe(rx_clk_oe), .o_lock_n(lock_n)
    );
    ecsl_remote_tx ecsl_remote_tx_i (
        .i_link_clk(link_clk), .i_break(far_break), .i_word(far_word),
        .o_serial(serial_in)
    );

    // last 12 driven bits, first sent bit in the msb
    always @(posedge link_clk) if (serial_oe) win <= {win[10:0], serial_out};

    function automatic logic [11:0] frame_of(input logic [9:0] w);
        logic [11:0] f;
        f[11] = 1'b1;
        for (int k = 0; k < 10; k++) f[10-k] = w[k];
        f[0] = 1'b0;
        return f;
    endfunction

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wait_bit(ref logic s, input logic v, input int lim);
        int n;
        for (n = 0; n < lim && s !== v; n++) @(negedge sys_clk);
        check({11'h000, s}, {11'h000, v});
        if (n == lim) end_sim();
    endtask

    task automatic wait_win(input logic [11:0] exp, input int lim);
        int n;
        for (n = 0; n < lim && win !== exp; n++) @(negedge link_clk);
        check(win, exp);
        if (n == lim) end_sim();
    endtask

    task automatic wait_word(input logic [9:0] w);
        int n;
        for (n = 0; n < 400 && word_out !== w; n++) @(negedge sys_clk);
        check({2'b00, word_out}, {2'b00, w});
        if (n == 400) end_sim();
    endtask

    initial begin
        repeat (2) @(negedge sys_clk);
        check({9'h000, lock_n, serial_oe, tx_ready}, 12'h004);
        rst_n = 1'b1;
        repeat (500) @(posedge tx_word_clock);
        check({10'h000, serial_oe, tx_ready}, 12'h000);
        wait_bit(tx_ready, 1'b1, 600);
        wait_bit(lock_n, 1'b0, 3000);
        check({10'h000, word_oe, rx_clk_oe}, 12'h003);
        foreach (rows[i]) begin
            @(negedge sys_clk);
            {edge_sel, word_in} = rows[i];
            far_word = rows[i][9:0];
            rx_edge = rows[i][10];
            wait_word(far_word);
            if (i > 0) check({11'h000, rx_clk}, {11'h000, ~rx_edge});
            @(negedge sys_clk);
            if (i > 0) check({11'h000, rx_clk}, {11'h000, rx_edge});
            wait_win(frame_of(word_in), 600);
        end
        for (int s = 0; s < 2; s++) begin
            @(negedge sys_clk);
            {sync_b, sync_a} = (s == 0) ? 2'b01 : 2'b10;
            wait_win(12'hfc0, 600);
            @(negedge sys_clk);
            {sync_b, sync_a} = 2'b00;
            wait_win(frame_of(word_in), 600);
        end
        @(negedge sys_clk);
        drive_en = 1'b0;
        wait_bit(serial_oe, 1'b0, 20);
        drive_en = 1'b1;
        wait_bit(serial_oe, 1'b1, 20);
        rx_oe = 1'b0;
        wait_bit(word_oe, 1'b0, 10);
        check({10'h000, rx_clk_oe, lock_n}, 12'h000);
        rx_oe = 1'b1;
        far_break = 1'b1;
        wait_bit(lock_n, 1'b1, 500);
        check({10'h000, word_oe, rx_clk_oe}, 12'h000);
        far_break = 1'b0;
        sync_a = 1'b1;
        wait_bit(lock_n, 1'b0, 3000);
        wait_win(12'hfc0, 600);
        @(negedge sys_clk);
        sync_a = 1'b0;
        pwr_n = 1'b0;
        wait_bit(tx_ready, 1'b0, 20);
        wait_bit(lock_n, 1'b1, 20);
        end_sim();
    end
endmodule

// File: sim/ecsl_remote_tx.sv
////////////////////////////////////////////////////////////////////////////////
// far-end serializer: sends one framed word every 12 link clocks
module ecsl_remote_tx (
    input wire logic i_link_clk,
    input wire logic i_break,
    input wire logic [9:0] i_word,
    output logic o_serial
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] bit_reg = 4'h0;
    initial o_serial = 1'b0;
    always @(posedge i_link_clk) begin
        bit_reg <= (bit_reg == 4'hb) ? 4'h0 : bit_reg + 4'h1;
        if (bit_reg == 4'h0) begin
            o_serial <= 1'b1;
        end else if (bit_reg == 4'hb) begin
            // a forced high stop bit breaks framing on command
            o_serial <= i_break;
        end else begin
            o_serial <= i_word[bit_reg - 4'h1];
        end
    end
endmodule

// File: src/ecsl_link.sv
////////////////////////////////////////////////////////////////////////////////
module ecsl_link #(
    parameter int WORD_W = ecsl_pkg::WORD_W,
    parameter int LOCK_FRAMES = ecsl_pkg::RX_LOCK_FRAMES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    input wire logic i_tx_word_clock,
    input wire logic [WORD_W-1:0] i_parallel_word_in,
    input wire logic i_tx_edge_select,
    input wire logic i_sync_request_a,
    input wire logic i_sync_request_b,
    input wire logic i_tx_drive_enable,
    input wire logic i_power_down_n,
    input wire logic i_rx_edge_select,
    input wire logic i_rx_output_enable,
    input wire logic i_serial_in,
    output logic o_serial_out,
    output logic o_serial_oe,
    output logic o_tx_ready,
    output logic [WORD_W-1:0] o_parallel_word_out,
    output logic o_parallel_word_oe,
    output logic o_rx_clk_out,
    output logic o_rx_clk_oe,
    output logic o_lock_n
);
    if (WORD_W != ecsl_pkg::WORD_W) begin : g_bad
        $error("ecsl_link: word width must be 10");
    end

    ////////////////////////////////////////////////////////////////////////////
    // system domain input synchronisers
    logic [ecsl_pkg::SYS_IN_W-1:0] sys_raw;
    logic [ecsl_pkg::SYS_IN_W-1:0] sys_s1_reg;
    logic [ecsl_pkg::SYS_IN_W-1:0] sys_s2_reg;
    logic [ecsl_pkg::SYS_IN_W-1:0] sys_s3_reg;
    logic [ecsl_pkg::SYS_IN_W-1:0] sys_in_reg;
    logic [15:0] sys_agree;
    logic rx_locked_link;
    logic rx_req_link_reg;
    logic tx_ack_link_reg;

    assign sys_raw = {tx_ack_link_reg, rx_req_link_reg, rx_locked_link, i_rx_output_enable,
        i_rx_edge_select, i_power_down_n, i_tx_drive_enable, i_tx_edge_select,
        i_sync_request_b, i_sync_request_a, i_tx_word_clock};
    assign sys_agree = ecsl_pkg::ecsl_agree(16'(sys_s2_reg), 16'(sys_s3_reg), 16'(sys_in_reg));

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_s1_reg <= '0;
            sys_s2_reg <= '0;
            sys_s3_reg <= '0;
            sys_in_reg <= '0;
        end else begin
            sys_s1_reg <= sys_raw;
            sys_s2_reg <= sys_s1_reg;
            sys_s3_reg <= sys_s2_reg;
            sys_in_reg <= sys_agree[ecsl_pkg::SYS_IN_W-1:0];
        end
    end

    logic wclk;
    logic sync_req;
    logic tx_edge_sel;
    logic drive_en;
    logic pwr_n;
    logic rx_edge_sel;
    logic rx_oe;
    logic rx_lock_sys;
    logic rx_req_sys;
    logic tx_ack_sys;
    logic wclk_prev_reg;
    logic wclk_rise;
    logic sel_edge;

    assign wclk = sys_in_reg[0];
    assign sync_req = sys_in_reg[1] | sys_in_reg[2];
    assign tx_edge_sel = sys_in_reg[3];
    assign drive_en = sys_in_reg[4];
    assign pwr_n = sys_in_reg[5];
    assign rx_edge_sel = sys_in_reg[6];
    assign rx_oe = sys_in_reg[7];
    assign rx_lock_sys = sys_in_reg[8];
    assign rx_req_sys = sys_in_reg[9];
    assign tx_ack_sys = sys_in_reg[10];
    assign wclk_rise = wclk && !wclk_prev_reg;
    assign sel_edge = tx_edge_sel ? wclk_rise : (!wclk && wclk_prev_reg);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wclk_prev_reg <= 1'b0;
        end else begin
            wclk_prev_reg <= wclk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit state machine
    ecsl_pkg::ecsl_tx_state_t state_reg;
    logic [9:0] init_cnt_reg;
    logic [2:0] sync_cnt_reg;
    logic ignore_reg;
    logic tx_oe_reg;
    logic sync_mode_reg;
    logic tx_req_reg;
    logic [WORD_W-1:0] tx_word_reg;
    logic tx_locked;

    assign tx_locked = (state_reg == ecsl_pkg::ECSL_TX_DATA) ||
        (state_reg == ecsl_pkg::ECSL_TX_RESYNC);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= ecsl_pkg::ECSL_TX_POWERDOWN;
            init_cnt_reg <= 10'h000;
        end else if (!pwr_n) begin
            state_reg <= ecsl_pkg::ECSL_TX_POWERDOWN;
            init_cnt_reg <= 10'h000;
        end else begin
            case (state_reg)
                ecsl_pkg::ECSL_TX_POWERDOWN: begin
                    state_reg <= ecsl_pkg::ECSL_TX_INIT;
                    init_cnt_reg <= 10'h000;
                end
                ecsl_pkg::ECSL_TX_INIT: begin
                    if (wclk_rise) begin
                        if (init_cnt_reg == ecsl_pkg::INIT_CYCLES - 10'h001) begin
                            state_reg <= sync_req ? ecsl_pkg::ECSL_TX_RESYNC
                                : ecsl_pkg::ECSL_TX_DATA;
                        end else begin
                            init_cnt_reg <= init_cnt_reg + 10'h001;
                        end
                    end
                end
                ecsl_pkg::ECSL_TX_DATA: begin
                    if (sync_req) begin
                        state_reg <= ecsl_pkg::ECSL_TX_RESYNC;
                    end
                end
                ecsl_pkg::ECSL_TX_RESYNC: begin
                    if (!sync_req) begin
                        state_reg <= ecsl_pkg::ECSL_TX_DATA;
                    end
                end
                default: begin
                    state_reg <= ecsl_pkg::ECSL_TX_POWERDOWN;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_cnt_reg <= 3'h0;
            ignore_reg <= 1'b0;
        end else if (!sync_req) begin
            sync_cnt_reg <= 3'h0;
            ignore_reg <= 1'b0;
        end else if (wclk_rise && sync_cnt_reg != ecsl_pkg::SYNC_IGNORE_CYCLES) begin
            sync_cnt_reg <= sync_cnt_reg + 3'h1;
            ignore_reg <= (sync_cnt_reg == ecsl_pkg::SYNC_IGNORE_CYCLES - 3'h1);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_oe_reg <= 1'b0;
            sync_mode_reg <= 1'b0;
            o_tx_ready <= 1'b0;
        end else begin
            tx_oe_reg <= tx_locked && drive_en && pwr_n;
            sync_mode_reg <= state_reg == ecsl_pkg::ECSL_TX_RESYNC;
            o_tx_ready <= tx_locked;
        end
    end

    // a word is taken only when the previous one reached the link side
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_word_reg <= ecsl_pkg::WORD_RESET;
            tx_req_reg <= 1'b0;
        end else if (state_reg == ecsl_pkg::ECSL_TX_DATA && sel_edge && !ignore_reg
            && tx_req_reg == tx_ack_sys) begin
            tx_word_reg <= i_parallel_word_in;
            tx_req_reg <= ~tx_req_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive side, system domain
    logic rx_ack_reg;
    logic rx_clk_pend_reg;
    logic [WORD_W-1:0] rx_hold_link_reg;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_ack_reg <= 1'b0;
            rx_clk_pend_reg <= 1'b0;
            o_parallel_word_out <= ecsl_pkg::WORD_RESET;
            o_rx_clk_out <= 1'b0;
            o_lock_n <= 1'b1;
            o_parallel_word_oe <= 1'b0;
            o_rx_clk_oe <= 1'b0;
        end else begin
            o_lock_n <= !(rx_lock_sys && pwr_n);
            o_parallel_word_oe <= rx_lock_sys && rx_oe && pwr_n;
            o_rx_clk_oe <= rx_lock_sys && rx_oe && pwr_n;
            rx_clk_pend_reg <= 1'b0;
            if (rx_req_sys != rx_ack_reg) begin
                rx_ack_reg <= rx_req_sys;
                if (rx_lock_sys) begin
                    o_parallel_word_out <= rx_hold_link_reg;
                    o_rx_clk_out <= !rx_edge_sel;
                    rx_clk_pend_reg <= 1'b1;
                end
            end else if (rx_clk_pend_reg) begin
                o_rx_clk_out <= rx_edge_sel;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain
    logic [ecsl_pkg::LINK_IN_W-1:0] lk_raw;
    logic [ecsl_pkg::LINK_IN_W-1:0] lk_s1_reg;
    logic [ecsl_pkg::LINK_IN_W-1:0] lk_s2_reg;
    logic [ecsl_pkg::LINK_IN_W-1:0] lk_s3_reg;
    logic [ecsl_pkg::LINK_IN_W-1:0] lk_in_reg;
    logic [15:0] lk_agree;
    logic oe_link;

    assign lk_raw = {tx_oe_reg, pwr_n, rx_ack_reg, sync_mode_reg, tx_req_reg};
    assign oe_link = lk_in_reg[4];
    assign lk_agree = ecsl_pkg::ecsl_agree(16'(lk_s2_reg), 16'(lk_s3_reg), 16'(lk_in_reg));

    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lk_s1_reg <= '0;
            lk_s2_reg <= '0;
            lk_s3_reg <= '0;
            lk_in_reg <= '0;
        end else begin
            lk_s1_reg <= lk_raw;
            lk_s2_reg <= lk_s1_reg;
            lk_s3_reg <= lk_s2_reg;
            lk_in_reg <= lk_agree[ecsl_pkg::LINK_IN_W-1:0];
        end
    end

    logic [3:0] tx_bit_reg;
    logic [ecsl_pkg::FRAME_BITS-1:0] tx_frame_reg;
    logic [WORD_W-1:0] tx_word_link_reg;
    logic tx_oe_link_reg;

    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_ack_link_reg <= 1'b0;
            tx_word_link_reg <= ecsl_pkg::WORD_RESET;
        end else if (lk_in_reg[0] != tx_ack_link_reg) begin
            tx_ack_link_reg <= lk_in_reg[0];
            tx_word_link_reg <= tx_word_reg;
        end
    end

    // the oe level from the system side is staged with the shifter
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_bit_reg <= 4'h0;
            // idle frame keeps start and stop bits legal from the first edge
            tx_frame_reg <= {1'b0, ecsl_pkg::WORD_RESET, 1'b1};
            tx_oe_link_reg <= 1'b0;
            o_serial_out <= 1'b0;
            o_serial_oe <= 1'b0;
        end else begin
            o_serial_out <= tx_frame_reg[tx_bit_reg];
            o_serial_oe <= tx_oe_link_reg;
            if (tx_bit_reg == ecsl_pkg::LAST_BIT) begin
                tx_bit_reg <= 4'h0;
                tx_oe_link_reg <= oe_link;
                tx_frame_reg <= lk_in_reg[1] ? ecsl_pkg::SYNC_PATTERN
                    : {1'b0, tx_word_link_reg, 1'b1};
            end else begin
                tx_bit_reg <= tx_bit_reg + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive framer and word hand-off
    logic rx_stb_link;
    logic [WORD_W-1:0] rx_word_link;

    ecsl_rx_framer #(
        .WORD_W(WORD_W),
        .LOCK_FRAMES(LOCK_FRAMES)
    ) u_rx_framer (
        .i_link_clk(i_link_clk),
        .i_rst_n(i_rst_n),
        .i_enable(lk_in_reg[3]),
        .i_serial_in(i_serial_in),
        .o_locked(rx_locked_link),
        .o_word_stb(rx_stb_link),
        .o_word(rx_word_link)
    );

    // words arriving while the previous hand-off is open are dropped
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_req_link_reg <= 1'b0;
            rx_hold_link_reg <= ecsl_pkg::WORD_RESET;
        end else if (rx_stb_link && rx_req_link_reg == lk_in_reg[2]) begin
            rx_hold_link_reg <= rx_word_link;
            rx_req_link_reg <= ~rx_req_link_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_tx_init_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        state_reg == ecsl_pkg::ECSL_TX_INIT |=> !tx_oe_reg
    ) else $error("transmit enabled during initialization");

    a_tx_init_length: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_reg == ecsl_pkg::ECSL_TX_INIT && wclk_rise && pwr_n
            && init_cnt_reg == ecsl_pkg::INIT_CYCLES - 10'h001) |=> tx_locked
    ) else $error("initialization length wrong");

    a_tx_sync_enter: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_reg == ecsl_pkg::ECSL_TX_DATA && pwr_n && sync_req)
            |=> state_reg == ecsl_pkg::ECSL_TX_RESYNC ##1 sync_mode_reg
    ) else $error("sync request not honoured");

    a_tx_sync_leave: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_reg == ecsl_pkg::ECSL_TX_RESYNC && pwr_n && !sync_req)
            |=> state_reg == ecsl_pkg::ECSL_TX_DATA ##1 !sync_mode_reg
    ) else $error("sync patterns continue after release");

    a_tx_ignore_word: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ignore_reg |=> $stable(tx_word_reg)
    ) else $error("word latched while ignoring");

    a_tx_edge_sel: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $changed(tx_req_reg) |-> $past(sel_edge) && $past(tx_locked)
    ) else $error("word latched off the selected edge");

    a_tx_frame_bits: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
        tx_bit_reg == 4'h0 |=> o_serial_out ##11 !o_serial_out
    ) else $error("start or stop bit wrong");

    a_rx_float_unlock: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_lock_n |-> !o_parallel_word_oe && !o_rx_clk_oe
    ) else $error("outputs driven while unlocked");
endmodule

// File: src/ecsl_pkg.sv
package ecsl_pkg;
    localparam int WORD_W = 10;
    localparam int FRAME_BITS = 12;
    localparam int SYNC_STAGES = 3;
    localparam int SYS_IN_W = 11;
    localparam int LINK_IN_W = 5;
    localparam logic [9:0] INIT_CYCLES = 10'd510;
    localparam logic [2:0] SYNC_IGNORE_CYCLES = 3'd5;
    localparam logic [3:0] LAST_BIT = 4'hb;
    localparam logic [11:0] SYNC_PATTERN = 12'h03f;
    localparam int RX_LOCK_FRAMES = 4;
    localparam logic [WORD_W-1:0] WORD_RESET = 10'h000;

    typedef enum logic [1:0] {
        ECSL_TX_POWERDOWN,
        ECSL_TX_INIT,
        ECSL_TX_DATA,
        ECSL_TX_RESYNC
    } ecsl_tx_state_t;

    // per bit: stage 3 once stages 2 and 3 agree, else the previous value
    function automatic logic [15:0] ecsl_agree(
        input logic [15:0] s2,
        input logic [15:0] s3,
        input logic [15:0] prev
    );
        ecsl_agree = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & prev);
    endfunction
endpackage

// File: src/ecsl_rx_framer.sv
module ecsl_rx_framer #(
    parameter int WORD_W = 10,
    parameter int LOCK_FRAMES = 4
) (
    input wire logic i_link_clk,
    input wire logic i_rst_n,
    input wire logic i_enable,
    input wire logic i_serial_in,
    output logic o_locked,
    output logic o_word_stb,
    output logic [WORD_W-1:0] o_word
);
    localparam int FB = WORD_W + 2;
    localparam logic [3:0] LAST = 4'(FB - 1);

    if (WORD_W != 10 || LOCK_FRAMES < 1 || LOCK_FRAMES > 15) begin : g_bad
        $error("ecsl_rx_framer: unsupported parameters");
    end

    logic [FB-1:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [3:0] good_cnt_reg;
    logic prev_bit_reg;
    logic hunting_reg;
    logic [FB-1:0] frame;

    assign frame = {i_serial_in, shift_reg[FB-1:1]};

    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_reg <= '0;
            prev_bit_reg <= 1'b0;
        end else begin
            shift_reg <= frame;
            prev_bit_reg <= i_serial_in;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hunting_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            good_cnt_reg <= 4'h0;
            o_locked <= 1'b0;
            o_word_stb <= 1'b0;
            o_word <= '0;
        end else begin
            o_word_stb <= 1'b0;
            if (!i_enable) begin
                hunting_reg <= 1'b0;
                bit_cnt_reg <= 4'h0;
                good_cnt_reg <= 4'h0;
                o_locked <= 1'b0;
            end else if (!hunting_reg) begin
                if (i_serial_in != prev_bit_reg) begin
                    hunting_reg <= 1'b1;
                    bit_cnt_reg <= 4'h1;
                end
            end else if (bit_cnt_reg == LAST) begin
                // start bit first, stop bit last
                if (frame[0] && !frame[FB-1]) begin
                    bit_cnt_reg <= 4'h0;
                    if (good_cnt_reg == 4'(LOCK_FRAMES - 1)) begin
                        o_locked <= 1'b1;
                    end else begin
                        good_cnt_reg <= good_cnt_reg + 4'h1;
                    end
                    if (o_locked) begin
                        o_word <= frame[FB-2:1];
                        o_word_stb <= 1'b1;
                    end
                end else begin
                    // slip one bit and start counting good frames again
                    bit_cnt_reg <= 4'h1;
                    good_cnt_reg <= 4'h0;
                    o_locked <= 1'b0;
                end
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    a_rx_lock_count: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
        $rose(o_locked) |-> $past(good_cnt_reg) == 4'(LOCK_FRAMES - 1)
    ) else $error("lock without enough framed words");

    a_rx_word_valid: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
        o_word_stb |-> o_locked && $past(o_locked)
    ) else $error("word strobe while unlocked");
endmodule
